/* shared/power_mode_pkg.sv */
package power_mode_pkg;

   // clock and settle timing
   localparam int CLK_PERIOD_NS   = 10;
   localparam int VOLT_SETTLE_NS  = 1000;
   localparam int VOLT_SETTLE_CYC = (VOLT_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SETTLE_W        = 8;

   // register byte offsets
   localparam logic [7:0] POWER_CONTROL_OFS = 8'h00;
   localparam logic [7:0] DORMANT_CTRL_OFS  = 8'h04;
   localparam logic [7:0] RETAIN_CFG_OFS    = 8'h08;
   localparam logic [7:0] WAKE_ROUTE_OFS    = 8'h0c;
   localparam logic [7:0] MODE_STATUS_OFS   = 8'h10;

   // power_control_reg fields
   localparam int PC_REDUCED_BIT  = 0;
   localparam int PC_READY_BIT    = 4;
   localparam int PC_CLKLIM_BIT   = 8;
   localparam int PC_REGLOW_BIT   = 9;

   // dormant_control_reg fields
   localparam int DC_REQ_BIT      = 31;
   localparam int DC_DISABLE_BIT  = 30;
   localparam int DC_RTC_EN_BIT   = 18;
   localparam int DC_COMP_EN_BIT  = 17;

   // wake route fields: low-power source mask per core
   localparam int WR_CORE0_LSB    = 0;
   localparam int WR_CORE1_LSB    = 8;

   // status fields
   localparam int ST_SYS_LSB      = 0;
   localparam int ST_CPU0_LSB     = 4;
   localparam int ST_CPU1_LSB     = 8;

   // reset values
   localparam logic [7:0] RETAIN_RST  = 8'hff;
   localparam logic [4:0] ROUTE_RST   = 5'h1f;
   localparam logic [7:0] SYNC_RST    = 8'h40;

   localparam int NUM_CORES = 2;
   localparam int LP_SRC_W  = 5;

   // system power modes, one-hot
   typedef enum logic [3:0] {
      SYS_NORMAL  = 4'b0001,
      SYS_REDUCED = 4'b0010,
      SYS_DEEP    = 4'b0100,
      SYS_DORMANT = 4'b1000
   } sys_mode_t;

   // cpu power modes, one-hot
   typedef enum logic [2:0] {
      CPU_ACTIVE = 3'b001,
      CPU_SLEEP  = 3'b010,
      CPU_DEEP   = 3'b100
   } cpu_mode_t;

   // asynchronous inputs, bundled for synchronising
   typedef struct packed {
      logic ready;     // low_power_ready_flag source
      logic external_reset_pin_n;    // external_reset_pin level
      logic wake_pin;  // dedicated wake pin
      logic rtc;       // backup domain alarm
      logic wdt;       // watchdog_unit interrupt
      logic serial_comm_block;       // serial_comm_block wake
      logic comp;      // low-power comparator
      logic gpio;      // gpio interrupt
   } async_in_t;

   // gating outputs
   typedef struct packed {
      logic hf_clk_en;
      logic lf_clk_en;
      logic lp_periph_en;
      logic periph_en;
      logic gpio_freeze;
      logic comp_en;
      logic flash_wr_block;
      logic clk_limit;
      logic reg_low;
   } gate_out_t;

endpackage : power_mode_pkg

/* rtl/power_mode_controller.sv */
`timescale 1ns/1ps
// Summary of operation
// - reduced mode, wait without deep request sleeps
// - wait with deep request: deep, irq wakes
// - system deep only when both cores deep
// - system deep stops fast clocks, keeps 32k
// - low-power sources wake deep as interrupt
// - sram retention in deep is configurable
// - dormant entered only by software write
// - dormant freezes gpio, stops all but comparator
// - dormant wakes: pins, reset, comp, watchdog, rtc
// - dormant wake is a full device reset
// - rtc alarm wakes deep when routed, dormant when enabled
// - each core's mode tracked independently
// - reset or wake puts core active
// - core sleep gates that core's clock
// - interrupt wakes only cores enabling it
// - deep core requests, system waits ready
// - after reset system in normal mode
// - reduced mode blocks flash writes, limits clocks
// - clock lowered before regulator drops
// - not ready: wait, enter when ready
// - both deep plus request bit: dormant
// - deep wake: waking core active, mode restored
// - dormant wake clears request bit
module power_mode_controller
   import power_mode_pkg::*;
#(
   parameter int SETTLE_CYC = VOLT_SETTLE_CYC  // regulator/clock settle time in cycles
) (
   input  wire logic                   i_mclk,
   input  wire logic                   i_reset,
   // register port
   input  wire logic [7:0]             i_addr,
   input  wire logic [31:0]            i_wdata,
   input  wire logic                   i_wr,
   input  wire logic                   i_rd,
   output logic      [31:0]            o_rdata,
   // core side, same clock
   input  wire logic [NUM_CORES-1:0]   i_core_wait,
   input  wire logic [NUM_CORES-1:0]   i_core_deep_request_bit,
   input  wire logic [NUM_CORES-1:0]   i_core_irq,
   output logic      [NUM_CORES-1:0]   o_core_clk_en,
   output logic      [NUM_CORES-1:0]   o_core_woke,
   // wake sources and pins, asynchronous
   input  wire async_in_t              i_async,
   // gating and reset
   output gate_out_t                   o_gate,
   output logic      [7:0]             o_sram_retain,
   output logic                        o_dormant_reset,
   output logic      [3:0]             o_sys_mode,
   output logic      [5:0]             o_cpu_mode
);

   // whole module state
   typedef struct packed {
      sys_mode_t                 sys;          // system mode
      cpu_mode_t [NUM_CORES-1:0] cpu;          // per-core mode
      logic                      prior_low;    // mode before deep: reduced
      logic                      want_low;     // software target voltage
      logic                      clk_limit;    // clocks held at reduced limits
      logic                      reg_low;      // regulator at low level
      logic [SETTLE_W-1:0]       settle;       // settle countdown
      logic                      dorm_req;     // dormant request bit
      logic                      dorm_dis;     // write-once disable
      logic                      dorm_rtc;     // rtc wake enable in dormant
      logic                      dorm_comp;    // comparator kept on in dormant
      logic [7:0]                retain;       // sram retention blocks
      logic [LP_SRC_W-1:0]       route0;       // deep wake sources to core 0
      logic [LP_SRC_W-1:0]       route1;       // deep wake sources to core 1
      async_in_t                 sync1;        // first synchroniser stage
      async_in_t                 sync2;        // second synchroniser stage
      logic [31:0]               rdata;        // read data
      logic                      dorm_rst;     // dormant wake reset pulse
      logic [NUM_CORES-1:0]      woke;         // wake pulse per core
   } state_t;

   state_t st;
   state_t next_st;

   // decoded helpers
   logic [LP_SRC_W-1:0] lp_src;       // synced low-power sources
   logic                both_deep;    // both cores in cpu deep
   logic                ready;        // synced ready flag
   logic                dorm_wake;    // any dormant wake event
   logic [NUM_CORES-1:0] deep_wake;   // per-core deep wake
   logic [31:0]         rd_word;      // read mux

   assign lp_src = {st.sync2.rtc, st.sync2.wdt, st.sync2.serial_comm_block, st.sync2.comp, st.sync2.gpio};
   assign ready  = st.sync2.ready;
   assign both_deep = (st.cpu[0] == CPU_DEEP) && (st.cpu[1] == CPU_DEEP);
   // dormant wake: pins, reset pin, optional comparator, watchdog, optional rtc
   assign dorm_wake = st.sync2.wake_pin | ~st.sync2.external_reset_pin_n | st.sync2.wdt
                    | (st.dorm_comp & st.sync2.comp)
                    | (st.dorm_rtc & st.sync2.rtc);
   // deep wake is routed per core; rtc always counts when routed
   assign deep_wake[0] = |(lp_src & st.route0);
   assign deep_wake[1] = |(lp_src & st.route1);

   // read mux
   always_comb begin
      rd_word = 32'h0000_0000;
      unique case (i_addr)
         POWER_CONTROL_OFS: begin
            rd_word[PC_REDUCED_BIT] = st.want_low;
            rd_word[PC_READY_BIT]   = ready;
            rd_word[PC_CLKLIM_BIT]  = st.clk_limit;
            rd_word[PC_REGLOW_BIT]  = st.reg_low;
         end
         DORMANT_CTRL_OFS: begin
            rd_word[DC_REQ_BIT]     = st.dorm_req;
            rd_word[DC_DISABLE_BIT] = st.dorm_dis;
            rd_word[DC_RTC_EN_BIT]  = st.dorm_rtc;
            rd_word[DC_COMP_EN_BIT] = st.dorm_comp;
         end
         RETAIN_CFG_OFS: begin
            rd_word[7:0] = st.retain;
         end
         WAKE_ROUTE_OFS: begin
            rd_word[WR_CORE0_LSB +: LP_SRC_W] = st.route0;
            rd_word[WR_CORE1_LSB +: LP_SRC_W] = st.route1;
         end
         MODE_STATUS_OFS: begin
            rd_word[ST_SYS_LSB +: 4]  = st.sys;
            rd_word[ST_CPU0_LSB +: 3] = st.cpu[0];
            rd_word[ST_CPU1_LSB +: 3] = st.cpu[1];
         end
         default: begin
            rd_word = 32'h0000_0000;  // unmapped reads as zero
         end
      endcase
   end

   // next-state logic
   always_comb begin
      next_st = st;
      next_st.dorm_rst = 1'b0;
      next_st.woke     = '0;
      // synchronisers: stage one feeds stage two only
      next_st.sync1 = i_async;
      next_st.sync2 = st.sync1;
      // read data stands for one cycle after the strobe
      next_st.rdata = i_rd ? rd_word : 32'h0000_0000;

      // register writes; dormant request only from active system modes
      if (i_wr) begin
         unique case (i_addr)
            POWER_CONTROL_OFS: begin
               next_st.want_low = i_wdata[PC_REDUCED_BIT];
            end
            DORMANT_CTRL_OFS: begin
               if (!st.dorm_dis && (st.sys == SYS_NORMAL || st.sys == SYS_REDUCED)) begin
                  next_st.dorm_req = i_wdata[DC_REQ_BIT];
               end
               // disable is write-once, cleared only by reset
               next_st.dorm_dis  = st.dorm_dis | i_wdata[DC_DISABLE_BIT];
               next_st.dorm_rtc  = i_wdata[DC_RTC_EN_BIT];
               next_st.dorm_comp = i_wdata[DC_COMP_EN_BIT];
            end
            RETAIN_CFG_OFS: begin
               next_st.retain = i_wdata[7:0];
            end
            WAKE_ROUTE_OFS: begin
               next_st.route0 = i_wdata[WR_CORE0_LSB +: LP_SRC_W];
               next_st.route1 = i_wdata[WR_CORE1_LSB +: LP_SRC_W];
            end
            default: begin
               next_st.want_low = st.want_low;  // other offsets ignored
            end
         endcase
      end
      if (st.dorm_dis) begin
         next_st.dorm_req = 1'b0;  // disabled dormant disarmed; a request written together with disable stays armed for one cycle
      end

      // per-core modes, each core on its own inputs
      for (int c = 0; c < NUM_CORES; c++) begin
         unique case (st.cpu[c])
            CPU_ACTIVE: begin
               if (i_core_wait[c] && (st.sys == SYS_NORMAL || st.sys == SYS_REDUCED)) begin
                  next_st.cpu[c] = i_core_deep_request_bit[c] ? CPU_DEEP
                                                              : CPU_SLEEP;
               end
            end
            CPU_SLEEP: begin
               if (i_core_irq[c]) begin
                  next_st.cpu[c] = CPU_ACTIVE;
                  next_st.woke[c] = 1'b1;
               end
            end
            CPU_DEEP: begin
               // an irq while system still active; aborts pending entry too
               if (i_core_irq[c] && st.sys != SYS_DEEP && st.sys != SYS_DORMANT) begin
                  next_st.cpu[c] = CPU_ACTIVE;
                  next_st.woke[c] = 1'b1;
               end
            end
            default: begin
               next_st.cpu[c] = CPU_ACTIVE;
            end
         endcase
      end

      // voltage stepping, only outside deep and dormant
      if (st.settle != '0) begin
         next_st.settle = st.settle - 1'b1;
      end
      unique case (st.sys)
         SYS_NORMAL: begin
            if (both_deep && st.dorm_req) begin
               next_st.sys = SYS_DORMANT;
            end else if (both_deep && ready) begin
               next_st.sys       = SYS_DEEP;
               next_st.prior_low = 1'b0;
            end else if (st.want_low) begin
               // lower the clocks first, then the regulator
               if (!st.clk_limit) begin
                  next_st.clk_limit = 1'b1;
                  next_st.settle    = SETTLE_W'(SETTLE_CYC);
               end else if (st.settle == '0) begin
                  next_st.reg_low = 1'b1;
                  next_st.sys     = SYS_REDUCED;
               end
            end else if (st.clk_limit && st.settle == '0) begin
               next_st.clk_limit = 1'b0;  // regulator is up, release clocks
            end
         end
         SYS_REDUCED: begin
            if (both_deep && st.dorm_req) begin
               next_st.sys = SYS_DORMANT;
            end else if (both_deep && ready) begin
               next_st.sys       = SYS_DEEP;
               next_st.prior_low = 1'b1;
            end else if (!st.want_low) begin
               // raise regulator, keep clocks limited until it settles
               next_st.reg_low = 1'b0;
               next_st.settle  = SETTLE_W'(SETTLE_CYC);
               next_st.sys     = SYS_NORMAL;
            end
         end
         SYS_DEEP: begin
            // only the routed cores wake, back to the prior mode
            if (|deep_wake) begin
               next_st.sys = st.prior_low ? SYS_REDUCED : SYS_NORMAL;
               for (int c = 0; c < NUM_CORES; c++) begin
                  if (deep_wake[c]) begin
                     next_st.cpu[c]  = CPU_ACTIVE;
                     next_st.woke[c] = 1'b1;
                  end
               end
            end
         end
         SYS_DORMANT: begin
            // wake is a full reset: modes, voltage state and request bit back to defaults, other config kept
            if (dorm_wake) begin
               next_st.sys       = SYS_NORMAL;
               next_st.dorm_rst  = 1'b1;
               next_st.dorm_req  = 1'b0;
               next_st.want_low  = 1'b0;
               next_st.clk_limit = 1'b0;
               next_st.reg_low   = 1'b0;
               next_st.settle    = '0;
               next_st.cpu       = {CPU_ACTIVE, CPU_ACTIVE};
               next_st.woke      = '1;
            end
         end
         default: begin
            next_st.sys = SYS_NORMAL;
         end
      endcase
   end

   // state register
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         st           <= '0;
         st.sys       <= SYS_NORMAL;
         st.cpu       <= {CPU_ACTIVE, CPU_ACTIVE};
         st.retain    <= RETAIN_RST;
         st.route0    <= ROUTE_RST;
         st.route1    <= ROUTE_RST;
         st.sync1     <= SYNC_RST;
         st.sync2     <= SYNC_RST;
      end else begin
         st <= next_st;
      end
   end

   // core clocks run only while active
   always_comb begin
      for (int c = 0; c < NUM_CORES; c++) begin
         o_core_clk_en[c] = (st.cpu[c] == CPU_ACTIVE);
      end
   end

   // gating decoded from the mode flops
   always_comb begin
      o_gate.hf_clk_en      = (st.sys == SYS_NORMAL) || (st.sys == SYS_REDUCED);
      o_gate.lf_clk_en      = (st.sys != SYS_DORMANT);
      o_gate.lp_periph_en   = (st.sys != SYS_DORMANT);
      o_gate.periph_en      = o_gate.hf_clk_en;
      o_gate.gpio_freeze    = (st.sys == SYS_DORMANT);
      o_gate.comp_en        = (st.sys != SYS_DORMANT) || st.dorm_comp;
      o_gate.flash_wr_block = st.reg_low || st.clk_limit;
      o_gate.clk_limit      = st.clk_limit;
      o_gate.reg_low        = st.reg_low;
   end

   // retention mask only matters in deep; full retention otherwise
   assign o_sram_retain   = (st.sys == SYS_DEEP) ? st.retain : 8'hff;
   assign o_dormant_reset = st.dorm_rst;
   assign o_core_woke     = st.woke;
   assign o_sys_mode      = st.sys;
   assign o_cpu_mode      = {st.cpu[1], st.cpu[0]};
   assign o_rdata         = st.rdata;

endmodule : power_mode_controller

/* test/power_mode_asserts.sv */
`timescale 1ns/1ps
module power_mode_asserts
   import power_mode_pkg::*;
(
   input  wire logic       i_mclk,
   input  wire logic       i_reset,
   input  wire logic [1:0] i_core_wait,
   input  wire logic [1:0] i_core_deep_request_bit,
   input  wire logic [1:0] i_core_irq,
   input  wire logic [1:0] o_core_clk_en,
   input  wire logic [1:0] o_core_woke,
   input  wire gate_out_t  o_gate,
   input  wire logic [7:0] o_sram_retain,
   input  wire logic       o_dormant_reset,
   input  wire logic [3:0] o_sys_mode,
   input  wire logic [5:0] o_cpu_mode
);
   // one clock domain, reset masks all checks
   default clocking cb @(posedge i_mclk); endclocking
   default disable iff (i_reset);

   // core0 takes a wait while running in a waking system mode
   sequence s_wait0(bit dp);
      i_core_wait[0] && i_core_deep_request_bit[0] == dp && o_cpu_mode[2:0] == CPU_ACTIVE
      && o_sys_mode inside {SYS_NORMAL, SYS_REDUCED};
   endsequence
   // dormant left: reset pulse for exactly one cycle
   sequence s_reset_pulse;
      o_dormant_reset && o_sys_mode == SYS_NORMAL ##1 !o_dormant_reset;
   endsequence

   sleep_entry_a: assert property (s_wait0(1'b0) |=> o_cpu_mode[2:0] == CPU_SLEEP)
      else $error("core0 did not sleep");
   deep_entry_a: assert property (s_wait0(1'b1) |=> o_cpu_mode[2:0] == CPU_DEEP)
      else $error("core0 did not go deep");
   sys_deep_a: assert property ($rose(o_sys_mode == SYS_DEEP)
      |-> $past(o_cpu_mode) == {CPU_DEEP, CPU_DEEP}) else $error("deep without both cores");
   deep_clocks_a: assert property (o_sys_mode == SYS_DEEP
      |-> !o_gate.hf_clk_en && !o_gate.periph_en && o_gate.lf_clk_en && o_gate.lp_periph_en)
      else $error("deep clock gating wrong");
   dormant_gates_a: assert property (o_sys_mode == SYS_DORMANT
      |-> o_gate.gpio_freeze && !o_gate.hf_clk_en && !o_gate.periph_en)
      else $error("dormant gating wrong");
   dormant_wake_a: assert property (!$past(i_reset) && $fell(o_sys_mode == SYS_DORMANT)
      |-> s_reset_pulse) else $error("dormant wake without reset pulse");
   clk_gate_a: assert property (o_core_clk_en ==
      {o_cpu_mode[5:3] == CPU_ACTIVE, o_cpu_mode[2:0] == CPU_ACTIVE})
      else $error("core clock enable mismatch");
   irq_wake_a: assert property (o_cpu_mode[2:0] == CPU_SLEEP && i_core_irq[0]
      |=> o_cpu_mode[2:0] == CPU_ACTIVE && o_core_woke[0]) else $error("core0 not woken");
   irq_stay_a: assert property (o_cpu_mode[5:3] == CPU_SLEEP && !i_core_irq[1]
      |=> o_cpu_mode[5:3] == CPU_SLEEP) else $error("core1 woke without irq");
   reset_start_a: assert property ($past(i_reset)
      |-> o_sys_mode == SYS_NORMAL && o_cpu_mode == {CPU_ACTIVE, CPU_ACTIVE})
      else $error("bad state after reset");
   retain_idle_a: assert property (o_sys_mode != SYS_DEEP |-> o_sram_retain == 8'hff)
      else $error("retention mask outside deep");
   reduced_limits_a: assert property (o_sys_mode == SYS_REDUCED
      |-> o_gate.flash_wr_block && o_gate.clk_limit) else $error("reduced limits off");
   lower_order_a: assert property ($rose(o_gate.reg_low)
      |-> o_gate.clk_limit && $past(o_gate.clk_limit)) else $error("voltage before clock");
endmodule : power_mode_asserts

bind power_mode_controller power_mode_asserts chk (
   .i_mclk(i_mclk), .i_reset(i_reset), .i_core_wait(i_core_wait),
   .i_core_deep_request_bit(i_core_deep_request_bit), .i_core_irq(i_core_irq),
   .o_core_clk_en(o_core_clk_en), .o_core_woke(o_core_woke), .o_gate(o_gate),
   .o_sram_retain(o_sram_retain), .o_dormant_reset(o_dormant_reset),
   .o_sys_mode(o_sys_mode), .o_cpu_mode(o_cpu_mode));

/* test/core_pair_model.sv */
`timescale 1ns/1ps
module core_pair_model
   import power_mode_pkg::*;
(
   input  wire logic       i_mclk,
   input  wire logic       i_reset,
   input  wire logic [1:0] i_want_wait,  // bench asks a core to idle
   input  wire logic [1:0] i_want_deep,  // deep request level per core
   input  wire logic [1:0] i_want_irq,   // pending enabled interrupt
   input  wire logic [1:0] i_clk_en,     // core clock from controller
   output logic      [1:0] o_wait,
   output logic      [1:0] o_deep,
   output logic      [1:0] o_irq
);
   // a gated core cannot execute its wait, so only running cores pulse
   always_ff @(posedge i_mclk) begin
      if (i_reset) begin
         o_wait <= 2'b00;
      end else begin
         o_wait <= i_want_wait & i_clk_en & ~o_wait;
      end
   end
   // request bit and interrupt are plain levels held by the core
   always_comb begin
      o_deep = i_want_deep;
      o_irq  = i_want_irq;
   end
endmodule : core_pair_model

/* test/tb_top.sv */
`timescale 1ns/1ps
module tb_top;
   import power_mode_pkg::*;
   logic        mclk = 1'b0;  // 100 MHz
   logic        reset;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata;
   logic        wr_stb, rd_stb, dres;
   logic [1:0]  want_wait, want_deep, want_irq, cwait, cdeep, cirq, clk_en, woke;
   async_in_t   async;        // wake sources
   gate_out_t   gate;
   logic [7:0]  retain;
   logic [3:0]  sys;
   logic [5:0]  cpu;
   int          errors, num_checks;

   always #5 mclk = ~mclk;

   // short settle keeps the voltage steps quick
   power_mode_controller #(.SETTLE_CYC(4)) uut (
      .i_mclk(mclk), .i_reset(reset), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_stb),
      .i_rd(rd_stb), .o_rdata(rdata), .i_core_wait(cwait), .i_core_deep_request_bit(cdeep),
      .i_core_irq(cirq), .o_core_clk_en(clk_en), .o_core_woke(woke), .i_async(async),
      .o_gate(gate), .o_sram_retain(retain), .o_dormant_reset(dres), .o_sys_mode(sys),
      .o_cpu_mode(cpu));
   core_pair_model cores (
      .i_mclk(mclk), .i_reset(reset), .i_want_wait(want_wait), .i_want_deep(want_deep),
      .i_want_irq(want_irq), .i_clk_en(clk_en), .o_wait(cwait), .o_deep(cdeep), .o_irq(cirq));

   task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic reg_wr(logic [7:0] a, logic [31:0] d);
      @(posedge mclk);
      addr   <= a;
      wdata  <= d;
      wr_stb <= 1'b1;
      @(posedge mclk);
      wr_stb <= 1'b0;
   endtask : reg_wr
   // read data stand only in the cycle after the strobe
   task automatic reg_rd(logic [7:0] a, output logic [31:0] d);
      @(posedge mclk);
      addr   <= a;
      rd_stb <= 1'b1;
      @(posedge mclk);
      rd_stb <= 1'b0;
      #1;
      d = rdata;
   endtask : reg_rd
   task automatic sleep_core(int c, logic dp);
      @(posedge mclk);
      want_deep[c] <= dp;
      want_wait[c] <= 1'b1;
      repeat (4) @(posedge mclk);
      want_wait[c] <= 1'b0;
      #1;
   endtask : sleep_core
   task automatic raise_irq(logic [1:0] m);
      @(posedge mclk);
      want_irq <= m;
      repeat (3) @(posedge mclk);
      want_irq <= 2'b00;
      #1;
   endtask : raise_irq
   // toggle a wake line long enough to pass the synchroniser
   task automatic pulse_src(int b);
      @(posedge mclk);
      async[b] <= ~async[b];
      repeat (6) @(posedge mclk);
      async[b] <= ~async[b];
   endtask : pulse_src
   task automatic wait_sys(logic [3:0] m);
      for (int n = 0; n < 200 && sys !== m; n++) @(posedge mclk);
      #1;
   endtask : wait_sys

   task automatic t_reset();
      logic [31:0] d;
      reg_rd(MODE_STATUS_OFS, d);
      check("status", d, {21'h0, CPU_ACTIVE, 1'b0, CPU_ACTIVE, SYS_NORMAL});
      reg_rd(RETAIN_CFG_OFS, d);
      check("retain cfg", d, {24'h0, RETAIN_RST});
      reg_rd(8'h20, d);
      check("unmapped", d, 32'h0);
      $display("done t_reset");
   endtask : t_reset
   task automatic t_sleep();
      sleep_core(0, 1'b0);
      sleep_core(1, 1'b0);
      check("both sleep", 32'(cpu), 32'({CPU_SLEEP, CPU_SLEEP}));
      check("clocks gated", 32'(clk_en), 32'h0);
      raise_irq(2'b01);
      check("core0 only", 32'(cpu), 32'({CPU_SLEEP, CPU_ACTIVE}));
      raise_irq(2'b10);
      check("both active", 32'(cpu), 32'({CPU_ACTIVE, CPU_ACTIVE}));
      $display("done t_sleep");
   endtask : t_sleep
   task automatic t_reduced();
      reg_wr(POWER_CONTROL_OFS, 32'h1);
      wait_sys(SYS_REDUCED);
      check("limits", 32'({gate.flash_wr_block, gate.clk_limit, gate.reg_low}), 32'h7);
      sleep_core(0, 1'b1);
      check("one deep", 32'({cpu, sys}), 32'({CPU_ACTIVE, CPU_DEEP, SYS_REDUCED}));
      raise_irq(2'b01);
      check("core0 back", 32'(cpu), 32'({CPU_ACTIVE, CPU_ACTIVE}));
      reg_wr(POWER_CONTROL_OFS, 32'h0);
      wait_sys(SYS_NORMAL);
      check("normal", 32'(gate.reg_low), 32'h0);
      $display("done t_reduced");
   endtask : t_reduced
   task automatic t_deep();
      reg_wr(RETAIN_CFG_OFS, 32'h0f);
      reg_wr(WAKE_ROUTE_OFS, 32'h0000_0100);
      sleep_core(0, 1'b1);
      sleep_core(1, 1'b1);
      repeat (10) @(posedge mclk);
      check("waits ready", 32'(sys), 32'(SYS_NORMAL));
      // an irq while entry still waits on ready aborts that core's entry
      raise_irq(2'b01);
      check("entry aborted", 32'(cpu), 32'({CPU_DEEP, CPU_ACTIVE}));
      sleep_core(0, 1'b1);
      async.ready <= 1'b1;
      wait_sys(SYS_DEEP);
      check("deep", 32'(sys), 32'(SYS_DEEP));
      check("retain", 32'(retain), 32'h0f);
      pulse_src(0);
      wait_sys(SYS_NORMAL);
      check("core1 woke", 32'(cpu), 32'({CPU_ACTIVE, CPU_DEEP}));
      raise_irq(2'b01);
      check("core0 back", 32'(cpu), 32'({CPU_ACTIVE, CPU_ACTIVE}));
      @(posedge mclk);
      async.ready <= 1'b0;
      $display("done t_deep");
   endtask : t_deep
   // wake pin, reset pin, rtc alarm, watchdog, comparator
   task automatic t_dormant();
      logic [31:0] d;
      int          src[5] = '{5, 6, 4, 3, 1};
      foreach (src[i]) begin
         reg_wr(DORMANT_CTRL_OFS, 32'h8006_0000);
         sleep_core(0, 1'b1);
         sleep_core(1, 1'b1);
         check("dormant", 32'(sys), 32'(SYS_DORMANT));
         check("frozen", 32'({gate.gpio_freeze, gate.hf_clk_en, gate.periph_en, gate.comp_en}),
               32'h9);
         pulse_src(src[i]);
         wait_sys(SYS_NORMAL);
         check("wake active", 32'(cpu), 32'({CPU_ACTIVE, CPU_ACTIVE}));
         reg_rd(DORMANT_CTRL_OFS, d);
         check("request cleared", d, 32'h0006_0000);
      end
      $display("done t_dormant");
   endtask : t_dormant

   task automatic summarize();
      $display("checks %0d mismatches %0d", num_checks, errors);
      if (errors == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize

   // main sequence
   initial begin
      {reset, addr, wdata, wr_stb, rd_stb, want_wait, want_deep, want_irq} = '0;
      reset = 1'b1;
      async = 8'h40;
      repeat (8) @(posedge mclk);
      reset <= 1'b0;
      t_reset();
      t_sleep();
      t_reduced();
      t_deep();
      t_dormant();
      summarize();
   end
   // hang guard
   initial begin
      #200us;
      errors++;
      summarize();
   end
endmodule : tb_top
